//--- rtl/hdis_top.sv
// Halted-debug interrupt select: AXI4-Lite registers and service mask output
//
// Overview of operation
// - Two 16-bit debug-enable registers, consulted only while halted in real-time mode.
// - While running, normal enables apply and debug-enable registers are ignored.
// - A maskable interrupt with its debug-enable bit set is time-critical.
// - While halted, serve only time-critical interrupts also normally enabled.
// - Software reads and writes each debug-enable bit; one marks, zero unmarks.
// - Software reset leaves both debug-enable registers unchanged.
// - Hardware reset clears every debug-enable bit to zero.
// - Upper bit 10 marks the OS service interrupt time-critical.
// - Upper bit 9 marks the trace log interrupt time-critical.
// - Upper bit 8 marks the bus fault interrupt time-critical.
// - Upper bits 0 to 7 map to vectors 16 to 23.
// - Lower bits 2 to 15 map to vectors 2 to 15.
// - Lower bits 1-0 and upper bits 15-11 read zero, ignore writes.
// - A normal-enable bit of one enables its interrupt, zero disables it.
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module hdis_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Core interrupt side
  input  wire logic [26:0] irq_pending,
  input  wire logic        halted_rt,
  input  wire logic        soft_reset,
  output logic [26:0]      irq_service,
  output logic             halted_rt_seen
);

  // ==========================================================
  // Storage
  hdis_pkg::hdis_en_pair_t debug_en;
  hdis_pkg::hdis_en_pair_t normal_en;
  hdis_pkg::hdis_wr_state_t wr_state;
  logic [3:0]              aw_addr;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;
  logic                    aw_held;
  logic                    w_held;
  logic [31:0]             pend_map;
  logic [31:0]             service_mask;
  logic [15:0]             next_lower;
  logic [15:0]             next_upper;
  logic                    wr_hit_dbg_lo;
  logic                    wr_hit_dbg_hi;
  logic                    wr_hit_nrm_lo;
  logic                    wr_hit_nrm_hi;
  logic                    wr_ok;
  logic                    rd_hit_dbg_lo;
  logic                    rd_hit_dbg_hi;
  logic                    rd_hit_nrm_lo;
  logic                    rd_hit_nrm_hi;
  logic                    rd_ok;

  // ==========================================================
  // Write channel capture: address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      aw_addr       <= 4'h0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= 1'b0;
      if (wr_state == hdis_pkg::WR_IDLE && !aw_held && s_axi_awvalid && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_state == hdis_pkg::WR_EXEC) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= 1'b0;
      if (wr_state == hdis_pkg::WR_IDLE && !w_held && s_axi_wvalid && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_state == hdis_pkg::WR_EXEC) begin
        w_held <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Write decode and new register values
  always_comb begin
    wr_hit_dbg_lo = 1'b0;
    wr_hit_dbg_hi = 1'b0;
    wr_hit_nrm_lo = 1'b0;
    wr_hit_nrm_hi = 1'b0;
    wr_ok         = 1'b1;
    if (aw_addr == hdis_pkg::ADDR_DEBUG_EN_LOWER) begin
      wr_hit_dbg_lo = 1'b1;
    end else if (aw_addr == hdis_pkg::ADDR_DEBUG_EN_UPPER) begin
      wr_hit_dbg_hi = 1'b1;
    end else if (aw_addr == hdis_pkg::ADDR_NORMAL_EN_LOWER) begin
      wr_hit_nrm_lo = 1'b1;
    end else if (aw_addr == hdis_pkg::ADDR_NORMAL_EN_UPPER) begin
      wr_hit_nrm_hi = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  // Merge strobed bytes, masking reserved bits
  always_comb begin
    next_lower = wr_hit_dbg_lo ? debug_en.lower : normal_en.lower;
    next_upper = wr_hit_dbg_hi ? debug_en.upper : normal_en.upper;
    if (w_strb[0]) begin
      next_lower[7:0] = w_data[7:0];
      next_upper[7:0] = w_data[7:0];
    end
    if (w_strb[1]) begin
      next_lower[15:8] = w_data[15:8];
      next_upper[15:8] = w_data[15:8];
    end
    next_lower = next_lower & hdis_pkg::LOWER_WRITABLE;
    next_upper = next_upper & hdis_pkg::UPPER_WRITABLE;
  end

  // ==========================================================
  // Write state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= hdis_pkg::WR_IDLE;
    end else begin
      case (wr_state)
        hdis_pkg::WR_IDLE: begin
          if (aw_held && w_held) begin
            wr_state <= hdis_pkg::WR_EXEC;
          end
        end
        hdis_pkg::WR_EXEC: begin
          wr_state <= hdis_pkg::WR_RESP;
        end
        hdis_pkg::WR_RESP: begin
          if (s_axi_bready) begin
            wr_state <= hdis_pkg::WR_IDLE;
          end
        end
        default: begin
          wr_state <= hdis_pkg::WR_IDLE;
        end
      endcase
    end
  end

  // Write response, raised as the stored write lands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= hdis_pkg::RESP_OKAY;
    end else if (wr_state == hdis_pkg::WR_EXEC) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? hdis_pkg::RESP_OKAY : hdis_pkg::RESP_SLVERR;
    end else if (wr_state == hdis_pkg::WR_RESP && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Debug-enable registers; soft_reset deliberately not used here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      debug_en.lower <= hdis_pkg::EN_RESET;
      debug_en.upper <= hdis_pkg::EN_RESET;
    end else if (wr_state == hdis_pkg::WR_EXEC) begin
      if (wr_hit_dbg_lo) begin
        debug_en.lower <= next_lower;
      end
      if (wr_hit_dbg_hi) begin
        debug_en.upper <= next_upper;
      end
    end
  end

  // Ordinary enable registers, also kept through software reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      normal_en.lower <= hdis_pkg::EN_RESET;
      normal_en.upper <= hdis_pkg::EN_RESET;
    end else if (wr_state == hdis_pkg::WR_EXEC) begin
      if (wr_hit_nrm_lo) begin
        normal_en.lower <= next_lower;
      end
      if (wr_hit_nrm_hi) begin
        normal_en.upper <= next_upper;
      end
    end
  end

  // ==========================================================
  // Read decode
  always_comb begin
    rd_hit_dbg_lo = 1'b0;
    rd_hit_dbg_hi = 1'b0;
    rd_hit_nrm_lo = 1'b0;
    rd_hit_nrm_hi = 1'b0;
    rd_ok         = 1'b1;
    if (s_axi_araddr == hdis_pkg::ADDR_DEBUG_EN_LOWER) begin
      rd_hit_dbg_lo = 1'b1;
    end else if (s_axi_araddr == hdis_pkg::ADDR_DEBUG_EN_UPPER) begin
      rd_hit_dbg_hi = 1'b1;
    end else if (s_axi_araddr == hdis_pkg::ADDR_NORMAL_EN_LOWER) begin
      rd_hit_nrm_lo = 1'b1;
    end else if (s_axi_araddr == hdis_pkg::ADDR_NORMAL_EN_UPPER) begin
      rd_hit_nrm_hi = 1'b1;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // ==========================================================
  // Read handshake: one-deep, answer one cycle after address taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
    end else begin
      s_axi_arready <= 1'b0;
      if (!s_axi_rvalid && !s_axi_arready && s_axi_arvalid) begin
        s_axi_arready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Read data, captured with the address; upper word always zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= hdis_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rresp <= rd_ok ? hdis_pkg::RESP_OKAY : hdis_pkg::RESP_SLVERR;
      if (rd_hit_dbg_lo) begin
        s_axi_rdata <= {16'h0000, debug_en.lower};
      end else if (rd_hit_dbg_hi) begin
        s_axi_rdata <= {16'h0000, debug_en.upper};
      end else if (rd_hit_nrm_lo) begin
        s_axi_rdata <= {16'h0000, normal_en.lower};
      end else if (rd_hit_nrm_hi) begin
        s_axi_rdata <= {16'h0000, normal_en.upper};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Map vectors onto register bit positions
  // Vectors 2..15 at lower bits 2..15; 16..23 at upper 0..7;
  // bus fault, trace log, OS service at upper 8, 9, 10
  always_comb begin
    pend_map        = 32'h0000_0000;
    pend_map[15:2]  = irq_pending[15:2];
    pend_map[23:16] = irq_pending[23:16];
    pend_map[hdis_pkg::UPPER_VECTOR_BASE + hdis_pkg::BUS_FAULT_BIT]  = irq_pending[24];
    pend_map[hdis_pkg::UPPER_VECTOR_BASE + hdis_pkg::TRACE_LOG_BIT]  = irq_pending[25];
    pend_map[hdis_pkg::UPPER_VECTOR_BASE + hdis_pkg::OS_SERVICE_BIT] = irq_pending[26];
  end

  // Service selection; maskable interrupts only, gated by pending
  hdis_select u_select (
    .pending      (pend_map),
    .normal_en    (normal_en),
    .debug_en     (debug_en),
    .halted_rt    (halted_rt),
    .service_mask (service_mask)
  );

  // ==========================================================
  // Registered outputs, updated every cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_service <= 27'h0000000;
    end else begin
      // Vectors 0 and 1 are not maskable and are never served here
      irq_service[1:0]   <= 2'h0;
      irq_service[23:2]  <= service_mask[23:2];
      irq_service[24]    <= service_mask[24];
      irq_service[25]    <= service_mask[25];
      irq_service[26]    <= service_mask[26];
    end
  end

  // Halt state as the selection saw it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halted_rt_seen <= 1'b0;
    end else begin
      halted_rt_seen <= halted_rt;
    end
  end

endmodule

`default_nettype wire

//--- rtl/hdis_pkg.sv
// Package for the halted-debug interrupt select block
package hdis_pkg;

  // ==========================================================
  // Register map
  localparam logic [3:0]  ADDR_DEBUG_EN_LOWER  = 4'h0;
  localparam logic [3:0]  ADDR_DEBUG_EN_UPPER  = 4'h4;
  localparam logic [3:0]  ADDR_NORMAL_EN_LOWER = 4'h8;
  localparam logic [3:0]  ADDR_NORMAL_EN_UPPER = 4'hc;

  // ==========================================================
  // Field layout and reset values
  localparam logic [15:0] LOWER_WRITABLE        = 16'hfffc;
  localparam logic [15:0] UPPER_WRITABLE        = 16'h07ff;
  localparam logic [15:0] EN_RESET              = 16'h0000;
  localparam int          OS_SERVICE_BIT        = 10;
  localparam int          TRACE_LOG_BIT         = 9;
  localparam int          BUS_FAULT_BIT         = 8;
  localparam int          UPPER_VECTOR_BASE     = 16;
  localparam int          IRQ_WIDTH             = 27;

  // ==========================================================
  // Bus answers
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Combined enable word, upper half in bits 31:16, lower half in bits 15:0
  typedef struct packed {
    logic [15:0] upper;
    logic [15:0] lower;
  } hdis_en_pair_t;

  // Write side state
  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_EXEC = 3'b010,
    WR_RESP = 3'b100
  } hdis_wr_state_t;

endpackage

//--- rtl/hdis_select.sv
// Per-interrupt service selection for running and halted modes
`timescale 1ns/100ps
`default_nettype none

module hdis_select (
  // Interrupt state
  input  wire logic [31:0]     pending,
  input  wire hdis_pkg::hdis_en_pair_t normal_en,
  input  wire hdis_pkg::hdis_en_pair_t debug_en,
  input  wire logic            halted_rt,
  // Result
  output logic [31:0]          service_mask
);

  // ==========================================================
  // Selection, one cell per interrupt bit
  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1) begin : g_bit
      always_comb begin
        if (halted_rt) begin
          service_mask[i] = pending[i] & normal_en[i] & debug_en[i];
        end else begin
          service_mask[i] = pending[i] & normal_en[i];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

//--- test/hdis_core_model.sv
// Behavioural model of the core's pending flags and emulation halt state
`timescale 1ns/100ps
`default_nettype none

module hdis_core_model (
  // Clock
  input  wire logic        aclk,
  // Requested core state
  input  wire logic [26:0] want_pend,
  input  wire logic        want_halt,
  // Towards the block
  output logic [26:0]      irq_pending,
  output logic             halted_rt
);
  // Vectors 0 and 1 are driven as asked, so the block must mask them itself
  initial irq_pending = 27'h0;
  initial halted_rt = 1'b0;
  always @(posedge aclk) begin
    irq_pending <= want_pend;
    halted_rt <= want_halt;
  end
endmodule

`default_nettype wire

//--- test/hdis_chk_sva.sv
// Checker for the halted-debug interrupt select block
`timescale 1ns/100ps
`default_nettype none

module hdis_chk (
  // Clock, reset and core side
  input wire logic        aclk, aresetn, halted_rt, soft_reset, halted_rt_seen,
  input wire logic [26:0] irq_pending, irq_service,
  // AXI4-Lite
  input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic        s_axi_rvalid, s_axi_rready,
  input wire logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb,
  input wire logic [31:0] s_axi_wdata, s_axi_rdata,
  input wire logic [1:0]  s_axi_bresp, s_axi_rresp
);
  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_clears:
    assert property (disable iff (1'b0) !aresetn |=> irq_service == 27'h0 && !s_axi_bvalid)
    else $error("Outputs not cleared by reset");
  a_pend_needed:
    assert property ((irq_service & ~$past(irq_pending)) == 27'h0)
    else $error("Service without pending flag");
  a_vec_low:
    assert property (irq_service[1:0] == 2'h0) else $error("Vectors 0 and 1 served");
  a_rdata_upper:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0) else $error("Upper read bits set");
  a_ready_pulse:
    assert property (s_axi_awready |=> !s_axi_awready) else $error("Address ready held");
  a_write_answer:
    assert property (s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("No write response");
  a_bresp_done:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("Response stuck");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("No read data");
  a_rresp_done:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("Read data stuck");
  a_halt_follow:
    assert property ($past(aresetn) |-> halted_rt_seen == $past(halted_rt))
    else $error("Halt state not followed");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_halt_serve: cover property (halted_rt && irq_service != 27'h0);
endmodule

bind hdis_top hdis_chk u_chk (.*);

`default_nettype wire

//--- test/hdis_top_tb.sv
// Testbench for the halted-debug interrupt select block
`timescale 1ns/100ps
`default_nettype none

module hdis_top_tb;
  // ==========================================================
  // Signals
  logic        aclk, aresetn, soft_reset, halted_rt, halted_rt_seen, want_halt;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [26:0] irq_pending, irq_service, want_pend;
  int          errors, compares;

  hdis_top dut (.*);
  hdis_core_model core (.aclk(aclk), .want_pend(want_pend), .want_halt(want_halt),
                        .irq_pending(irq_pending), .halted_rt(halted_rt));

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 40);
    s_axi_bready <= 1'b0;
    if (n >= 40) begin
      errors++;
      complete_run();
    end else begin
      check({30'h0, s_axi_bresp}, {30'h0, er});
    end
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 40);
    s_axi_rready <= 1'b0;
    if (n >= 40) begin
      errors++;
      complete_run();
    end else begin
      check(s_axi_rdata, exp);
      check({30'h0, s_axi_rresp}, {30'h0, er});
    end
  endtask

  // Model adds one cycle, the block one more
  task automatic svc(input logic [26:0] p, input logic h, input logic [26:0] exp);
    @(posedge aclk);
    want_pend <= p;
    want_halt <= h;
    repeat (3) @(posedge aclk);
    #1 check({5'h0, irq_service}, {5'h0, exp});
    check({31'h0, halted_rt_seen}, {31'h0, h});
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    for (int i = 0; i < 4; i++) rdchk(4'(4 * i), 32'h0, 2'h0);
    $display("reset values done");
  endtask

  task automatic t_access;
    for (int i = 0; i < 4; i++) begin
      wr(4'(4 * i), 16'hffff, 2'h0);
      rdchk(4'(4 * i), i[0] ? 32'h07ff : 32'hfffc, 2'h0);
      wr(4'(4 * i), 16'h0, 2'h0);
      rdchk(4'(4 * i), 32'h0, 2'h0);
    end
    wr(4'h2, 16'hffff, 2'h2);
    rdchk(4'h2, 32'h0, 2'h2);
    $display("register access done");
  endtask

  task automatic t_map;
    wr(4'h8, 16'hffff, 2'h0);
    wr(4'hc, 16'hffff, 2'h0);
    for (int v = 2; v < 27; v++) begin
      wr(4'h0, v < 16 ? 16'(1 << v) : 16'h0, 2'h0);
      wr(4'h4, v < 16 ? 16'h0 : 16'(1 << (v - 16)), 2'h0);
      svc(27'h7ffffff, 1'b1, 27'(1 << v));
    end
    svc(27'h7ffffff, 1'b0, 27'h7fffffc);
    svc(27'h0, 1'b1, 27'h0);
    wr(4'hc, 16'h0, 2'h0);
    svc(27'h7ffffff, 1'b1, 27'h0);
    $display("service map done");
  endtask

  task automatic t_resets;
    wr(4'h0, 16'h1234, 2'h0);
    @(posedge aclk);
    soft_reset <= 1'b1;
    @(posedge aclk);
    soft_reset <= 1'b0;
    rdchk(4'h0, 32'h1234, 2'h0);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(4'h0, 32'h0, 2'h0);
    $display("resets done");
  endtask

  // ==========================================================
  // Clock and main sequence
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  initial begin
    errors = 0;
    compares = 0;
    aresetn = 1'b0;
    soft_reset = 1'b0;
    want_halt = 1'b0;
    want_pend = 27'h0;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_access();
    t_map();
    t_resets();
    complete_run();
  end
endmodule

`default_nettype wire
